// ### design/conv_result_chan.sv
`timescale 1ns/100ps
module conv_result_chan #(
    parameter int W = 12
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         store,
    input  wire logic [W-1:0] value_in,
    input  wire logic         low_read,
    output logic      [W-1:0] value_q,
    output logic              overrun_q,
    output logic              stored_q
);
    logic [W-1:0] value_d;
    logic         overrun_d;
    logic         stored_d;

    always_comb begin
        value_d   = value_q;
        overrun_d = overrun_q;
        stored_d  = stored_q;
        if (low_read) begin
            overrun_d = 1'b0;
            stored_d  = 1'b0;
        end
        if (store) begin
            value_d   = value_in;
            stored_d  = 1'b1;
            if (stored_q && !low_read) begin
                overrun_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q   <= '0;
            overrun_q <= 1'b0;
            stored_q  <= 1'b0;
        end else begin
            value_q   <= value_d;
            overrun_q <= overrun_d;
            stored_q  <= stored_d;
        end
    end
endmodule

// ### design/conv_result_pkg.sv
package conv_result_pkg;
    localparam int          NUM_CH          = 4;
    localparam int          RESULT_W        = 12;
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_RESULT_CH5  = 12'h000;
    localparam logic [11:0] OFS_RESULT_CH6  = 12'h004;
    localparam logic [11:0] OFS_RESULT_CH7  = 12'h008;
    localparam logic [11:0] OFS_RESULT_CH8  = 12'h00c;
    localparam int          POS_VALUE_LSB   = 4;
    localparam int          POS_OVERRUN     = 1;
    localparam int          POS_STORED      = 0;
    localparam logic [11:0] RESET_VALUE     = 12'h000;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
endpackage

// ### design/conv_result_regs.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module conv_result_regs #(
    parameter int NUM_CH   = conv_result_pkg::NUM_CH,
    parameter int RESULT_W = conv_result_pkg::RESULT_W
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [NUM_CH-1:0]          result_store,
    input  wire logic [NUM_CH*RESULT_W-1:0] result_data
);
    logic [NUM_CH-1:0]          low_read;
    logic [NUM_CH*RESULT_W-1:0] value_q;
    logic [NUM_CH-1:0]          overrun_q;
    logic [NUM_CH-1:0]          stored_q;
    logic [31:0]                prdata_d;
    logic                       pready_d;
    logic                       pslverr_d;
    logic [NUM_CH-1:0]          sel_ch;
    logic                       hit;
    logic                       setup;

    assign setup = psel && !penable;

    // Channel decode; every access is a full word so it covers the low byte
    always_comb begin
        sel_ch = '0;
        hit    = 1'b1;
        if (paddr == conv_result_pkg::OFS_RESULT_CH5) begin
            sel_ch[0] = 1'b1;
        end else if (paddr == conv_result_pkg::OFS_RESULT_CH6) begin
            sel_ch[1] = 1'b1;
        end else if (paddr == conv_result_pkg::OFS_RESULT_CH7) begin
            sel_ch[2] = 1'b1;
        end else if (paddr == conv_result_pkg::OFS_RESULT_CH8) begin
            sel_ch[3] = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Flags clear at the setup edge, where the read word is captured, so a
    // result stored after that edge stays flagged for the next read
    assign low_read = (setup && !pwrite) ? sel_ch : '0;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            conv_result_chan #(
                .W (RESULT_W)
            ) u_chan (
                .pclk      (pclk),
                .presetn   (presetn),
                .store     (result_store[g]),
                .value_in  (result_data[g*RESULT_W +: RESULT_W]),
                .low_read  (low_read[g]),
                .value_q   (value_q[g*RESULT_W +: RESULT_W]),
                .overrun_q (overrun_q[g]),
                .stored_q  (stored_q[g])
            );
        end
    endgenerate

    // Read data is captured in setup so prdata comes from a flip-flop
    always_comb begin
        prdata_d  = prdata;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup) begin
            pready_d  = 1'b1;
            pslverr_d = !hit || pwrite;
            prdata_d  = conv_result_pkg::RESET_WORD;
            for (int i = 0; i < NUM_CH; i++) begin
                if (sel_ch[i] && !pwrite) begin
                    prdata_d[conv_result_pkg::POS_VALUE_LSB +: RESULT_W] =
                        value_q[i*RESULT_W +: RESULT_W];
                    prdata_d[conv_result_pkg::POS_OVERRUN] = overrun_q[i];
                    prdata_d[conv_result_pkg::POS_STORED]  = stored_q[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= conv_result_pkg::RESET_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end
endmodule

// ### tb/conv_engine_model.sv
`timescale 1ns/100ps
module conv_engine_model (
    input  wire logic        pclk,
    output logic      [3:0]  result_store = 4'h0,
    output logic      [47:0] result_data = '1
);
    task automatic put(input int ch, input logic [11:0] v);
        @(posedge pclk);
        result_store[ch] <= 1'b1;
        result_data[ch*12+:12] <= v;
        @(posedge pclk);
        result_store <= 4'h0;
        result_data[ch*12+:12] <= ~v;
    endtask
endmodule

// ### tb/conv_result_checker.sv
`timescale 1ns/100ps
module conv_result_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ZERO: assert property (pready |-> !prdata[31:16] && !prdata[3:2])
        else $error("zero bits set");
    AST_OVR: assert property (pready && prdata[1] |-> prdata[0])
        else $error("overrun without result");
    AST_RDY: assert property (psel && !penable |=> pready) else $error("no answer");
    AST_ONE: assert property (pready |=> !pready) else $error("long answer");
    AST_IDLE: assert property (!psel |=> !pready) else $error("stray answer");
    AST_WERR: assert property (pready && pwrite |-> pslverr) else $error("write taken");
    AST_UNMAP: assert property (pready && pslverr |-> !prdata) else $error("error data");
    cover property (pready && prdata[1]);
    cover property (pready && prdata[0]);
    cover property (pready && pslverr);
endmodule
bind conv_result_regs conv_result_checker conv_result_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// ### tb/test_conv_result_regs.sv
`timescale 1ns/100ps
module test_conv_result_regs;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] prdata;
    logic [3:0]  st;
    logic [47:0] dat;
    int          miscompares = 0, n_tests = 0;
    always #4 pclk = ~pclk;
    conv_result_regs conv_result_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(32'hffff_ffff),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .result_store(st), .result_data(dat));
    conv_engine_model conv_engine_model_i (.pclk(pclk), .result_store(st), .result_data(dat));
    task automatic end_sim;
        $display("mismatches %0d of %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] e, input logic x);
        @(posedge pclk);
        {psel, pwrite, paddr} <= {1'b1, w, a};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        n_tests++;
        if (pready !== 1'b1 || pslverr !== x || (!w && prdata !== e)) begin
            miscompares++;
            $display("CHECK FAILED %0t: %h read %h", $time, a, prdata);
        end
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) acc(0, 12'(4 * i), 32'h0, 0);
        for (int i = 0; i < 4; i++) begin
            conv_engine_model_i.put(i, 12'hfff >> i);
            acc(0, 12'(4 * i), {16'h0, 12'hfff >> i, 4'h1}, 0);
            acc(0, 12'(4 * i), {16'h0, 12'hfff >> i, 4'h0}, 0);
        end
        conv_engine_model_i.put(1, 12'h123);
        conv_engine_model_i.put(1, 12'h456);
        acc(0, 12'h004, 32'h0000_4563, 0);
        acc(0, 12'h004, 32'h0000_4560, 0);
        conv_engine_model_i.put(2, 12'h7ab);
        fork
            conv_engine_model_i.put(2, 12'h9c1);
            acc(0, 12'h008, 32'h0000_7ab1, 0);
        join
        acc(0, 12'h008, 32'h0000_9c11, 0);
        conv_engine_model_i.put(2, 12'h3e5);
        fork
            begin
                @(posedge pclk);
                conv_engine_model_i.put(2, 12'h0d2);
            end
            acc(0, 12'h008, 32'h0000_3e51, 0);
        join
        acc(0, 12'h008, 32'h0000_0d21, 0);
        acc(1, 12'h000, 32'h0, 1);
        acc(0, 12'h000, 32'h0000_fff0, 0);
        acc(0, 12'h010, 32'h0, 1);
        conv_engine_model_i.put(3, 12'h5a5);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, 12'h00c, 32'h0, 0);
        end_sim;
    end
    initial begin
        #20000;
        miscompares++;
        end_sim;
    end
endmodule
